// ==== rtl/vpm_ecc.sv ====
`timescale 1ns/1ns
`default_nettype none
// SEC-DED check over a 32-bit entry: 6 Hamming bits plus overall parity.
module vpm_ecc (
    input  wire logic [vpm_pkg::ENT_W-1:0] i_data,
    input  wire logic [vpm_pkg::ECC_W-1:0] i_check,
    output logic      [vpm_pkg::ECC_W-1:0] o_gen,
    output logic                           o_corr,
    output logic                           o_uncorr
);
    function automatic logic [vpm_pkg::ECC_W-1:0] gen_code(input logic [vpm_pkg::ENT_W-1:0] d);
        logic [vpm_pkg::ECC_W-1:0] c;
        c = '0;
        for (int i = 0; i < vpm_pkg::ENT_W; i++) begin
            for (int b = 0; b < vpm_pkg::ECC_W - 1; b++) begin
                if (((i + 1 + b) >> b) % 2 == 1) begin
                    c[b] = c[b] ^ d[i];
                end
            end
        end
        c[vpm_pkg::ECC_W-1] = ^d ^ ^c[vpm_pkg::ECC_W-2:0];
        return c;
    endfunction : gen_code

    logic [vpm_pkg::ECC_W-1:0] syn;

    always_comb begin
        o_gen    = gen_code(i_data);
        syn      = o_gen ^ i_check;
        // Overall parity spans the data and every stored check bit, so one flipped check bit is correctable
        o_corr   = ^{i_data, i_check};
        o_uncorr = !o_corr && (syn != '0);
    end
endmodule : vpm_ecc
`default_nettype wire

// ==== rtl/vpm_pkg.sv ====
// Functional notes
// - Reset to pass-through; mode in utility bits 19:17
// - Pass-through needs VME bits 31:29 zero
// - Pass-through: zero top, copy bits 28:0
// - 34-bit mode maps 32 MB, bits 31:25 zero
// - 34-bit mode indexes map with bits 24:9
// - Entry bit 31 clear aborts transfer
// - Uncorrectable entry ECC error aborts transfer
// - Range, fetch, valid, ECC, then address
// - 34-bit: entry 24:0 onto 33:9
// - 40-bit 512B: bits 31:25 zero, index 24:9
// - 40-bit 512B: entry 29:0 onto 38:9
// - 40-bit modes force bit 39 zero
// - 4KB pages: bits 31:28 zero, index 27:12
// - 4KB pages: entry 26:0 onto 38:12
// - 8KB pages: bits 31:29 zero, index 28:13
// - 8KB pages: entry 25:0 above 13-bit offset
package vpm_pkg;

    localparam int VME_AW = 32;
    localparam int SYS_AW = 40;
    localparam int ENT_W  = 32;
    localparam int IDX_W  = 16;
    localparam int ECC_W  = 7;
    localparam int RAW_W  = 8;
    localparam int DAT_W  = 32;

    // Register offsets (byte addresses)
    localparam logic [RAW_W-1:0] REG_UTIL   = 8'h00;
    localparam logic [RAW_W-1:0] REG_STATUS = 8'h04;
    localparam logic [RAW_W-1:0] REG_MASK   = 8'h08;
    localparam logic [RAW_W-1:0] REG_ERRADR = 8'h0C;
    localparam logic [RAW_W-1:0] REG_MAPIDX = 8'h10;
    localparam logic [RAW_W-1:0] REG_MAPDAT = 8'h14;
    localparam logic [RAW_W-1:0] REG_MAPECC = 8'h18;

    localparam int MODE_LSB = 17;
    localparam int MODE_MSB = 19;

    localparam int ST_INVALID = 0;
    localparam int ST_UNCORR  = 1;
    localparam int ST_CORR    = 2;
    localparam int ST_W       = 3;

    localparam int ENT_VALID_BIT = 31;

    typedef enum logic [2:0] {
        VPM_MODE_PASS  = 3'h0,
        VPM_MODE_34    = 3'h1,
        VPM_MODE_40    = 3'h2,
        VPM_MODE_40_4K = 3'h3,
        VPM_MODE_40_8K = 3'h4
    } vpm_mode_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [VME_AW-1:0] addr;
    } vpm_req_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [SYS_AW-1:0] addr;
    } vpm_sys_t;

endpackage : vpm_pkg

// ==== rtl/vpm_translator.sv ====
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module vpm_translator #(
    parameter int IDX_W = vpm_pkg::IDX_W
) (
    input  wire logic                          i_core_clk,
    input  wire logic                          i_reset_n,
    input  wire vpm_pkg::vpm_req_t             i_req,
    output vpm_pkg::vpm_sys_t                  o_sys,
    output logic                               o_accept,
    output logic                               o_abort,
    input  wire logic [vpm_pkg::RAW_W-1:0]     i_reg_addr,
    input  wire logic [vpm_pkg::DAT_W-1:0]     i_reg_wdata,
    input  wire logic                          i_reg_wr,
    input  wire logic                          i_reg_rd,
    output logic      [vpm_pkg::DAT_W-1:0]     o_reg_rdata,
    output logic                               o_irq
);
    typedef enum logic [1:0] {VPM_IDLE, VPM_FETCH, VPM_CHECK} vpm_state_t;

    logic [vpm_pkg::ENT_W-1:0] map_data [2**IDX_W];
    logic [vpm_pkg::ECC_W-1:0] map_ecc  [2**IDX_W];

    vpm_state_t                state_q;
    vpm_pkg::vpm_mode_t        mode_q;
    vpm_pkg::vpm_req_t         cur_q;
    logic [vpm_pkg::ENT_W-1:0] ent_q;
    logic [vpm_pkg::ECC_W-1:0] chk_q;
    logic [IDX_W-1:0]          sw_idx_q;
    logic [vpm_pkg::ST_W-1:0]  status_q;
    logic [vpm_pkg::ST_W-1:0]  mask_q;
    logic [vpm_pkg::VME_AW-1:0] err_addr_q;
    logic                      ecc_corr;
    logic                      ecc_uncorr;
    logic [vpm_pkg::ST_W-1:0]  ev_set;

    function automatic logic range_ok(input vpm_pkg::vpm_mode_t m, input logic [vpm_pkg::VME_AW-1:0] a);
        unique case (m)
            vpm_pkg::VPM_MODE_PASS:  range_ok = a[31:29] == 3'h0;
            vpm_pkg::VPM_MODE_34:    range_ok = a[31:25] == 7'h00;
            vpm_pkg::VPM_MODE_40:    range_ok = a[31:25] == 7'h00;
            vpm_pkg::VPM_MODE_40_4K: range_ok = a[31:28] == 4'h0;
            vpm_pkg::VPM_MODE_40_8K: range_ok = a[31:29] == 3'h0;
            default:                 range_ok = 1'b0;
        endcase
    endfunction : range_ok

    function automatic logic [IDX_W-1:0] map_index(input vpm_pkg::vpm_mode_t m,
                                                    input logic [vpm_pkg::VME_AW-1:0] a);
        unique case (m)
            vpm_pkg::VPM_MODE_40_4K: map_index = a[27:12];
            vpm_pkg::VPM_MODE_40_8K: map_index = a[28:13];
            default:                 map_index = a[24:9];
        endcase
    endfunction : map_index

    function automatic logic [vpm_pkg::SYS_AW-1:0] sys_addr(input vpm_pkg::vpm_mode_t m,
                                                             input logic [vpm_pkg::VME_AW-1:0] a,
                                                             input logic [vpm_pkg::ENT_W-1:0] e);
        unique case (m)
            vpm_pkg::VPM_MODE_34:    sys_addr = {6'h00, e[24:0], a[8:0]};
            vpm_pkg::VPM_MODE_40:    sys_addr = {1'b0, e[29:0], a[8:0]};
            vpm_pkg::VPM_MODE_40_4K: sys_addr = {1'b0, e[26:0], a[11:0]};
            vpm_pkg::VPM_MODE_40_8K: sys_addr = {1'b0, e[25:0], a[12:0]};
            default:                 sys_addr = {11'h000, a[28:0]};
        endcase
    endfunction : sys_addr

    vpm_ecc u_ecc (
        .i_data   (ent_q),
        .i_check  (chk_q),
        .o_gen    (),
        .o_corr   (ecc_corr),
        .o_uncorr (ecc_uncorr)
    );

    // Translation pipeline: range check, fetch, then valid and ECC tests
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q  <= VPM_IDLE;
            cur_q    <= '0;
            o_sys    <= '0;
            o_accept <= 1'b0;
            o_abort  <= 1'b0;
        end else begin
            o_sys.valid <= 1'b0;
            o_accept    <= 1'b0;
            o_abort     <= 1'b0;
            unique case (state_q)
                VPM_IDLE: begin
                    // The master still holds a just-taken request while o_accept is high; never take it twice
                    if (i_req.valid && !o_accept && range_ok(mode_q, i_req.addr)) begin
                        o_accept <= 1'b1;
                        cur_q    <= i_req;
                        if (mode_q == vpm_pkg::VPM_MODE_PASS) begin
                            o_sys <= '{valid: 1'b1, write: i_req.write,
                                       addr: sys_addr(mode_q, i_req.addr, '0)};
                        end else begin
                            state_q <= VPM_FETCH;
                        end
                    end
                end
                VPM_FETCH: begin
                    state_q <= VPM_CHECK;
                end
                VPM_CHECK: begin
                    state_q <= VPM_IDLE;
                    if (!ent_q[vpm_pkg::ENT_VALID_BIT] || ecc_uncorr) begin
                        o_abort <= 1'b1;
                    end else begin
                        o_sys <= '{valid: 1'b1, write: cur_q.write,
                                   addr: sys_addr(mode_q, cur_q.addr, ent_q)};
                    end
                end
                default: state_q <= VPM_IDLE;
            endcase
        end
    end

    function automatic logic [vpm_pkg::ECC_W-1:0] gen_code_w(input logic [vpm_pkg::ENT_W-1:0] d);
        logic [vpm_pkg::ECC_W-1:0] c;
        c = '0;
        for (int i = 0; i < vpm_pkg::ENT_W; i++) begin
            for (int b = 0; b < vpm_pkg::ECC_W - 1; b++) begin
                if (((i + 1 + b) >> b) % 2 == 1) begin
                    c[b] = c[b] ^ d[i];
                end
            end
        end
        c[vpm_pkg::ECC_W-1] = ^d ^ ^c[vpm_pkg::ECC_W-2:0];
        return c;
    endfunction : gen_code_w

    // Map table: software writes by index; only the fetch step loads the entry under test
    always_ff @(posedge i_core_clk) begin
        if (i_reg_wr && i_reg_addr == vpm_pkg::REG_MAPDAT) begin
            map_data[sw_idx_q] <= i_reg_wdata;
            map_ecc[sw_idx_q]  <= gen_code_w(i_reg_wdata);
        end else if (i_reg_wr && i_reg_addr == vpm_pkg::REG_MAPECC) begin
            map_ecc[sw_idx_q] <= i_reg_wdata[vpm_pkg::ECC_W-1:0];
        end
        if (state_q == VPM_FETCH) begin
            ent_q <= map_data[map_index(mode_q, cur_q.addr)];
            chk_q <= map_ecc[map_index(mode_q, cur_q.addr)];
        end
    end

    // Control registers
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_q   <= vpm_pkg::VPM_MODE_PASS;
            mask_q   <= '0;
            sw_idx_q <= '0;
        end else if (i_reg_wr) begin
            unique case (i_reg_addr)
                vpm_pkg::REG_UTIL:   mode_q <= vpm_pkg::vpm_mode_t'(i_reg_wdata[vpm_pkg::MODE_MSB:vpm_pkg::MODE_LSB]);
                vpm_pkg::REG_MASK:   mask_q <= i_reg_wdata[vpm_pkg::ST_W-1:0];
                vpm_pkg::REG_MAPIDX: sw_idx_q <= i_reg_wdata[IDX_W-1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        ev_set = '0;
        if (state_q == VPM_CHECK) begin
            ev_set[vpm_pkg::ST_INVALID] = !ent_q[vpm_pkg::ENT_VALID_BIT];
            ev_set[vpm_pkg::ST_UNCORR]  = ent_q[vpm_pkg::ENT_VALID_BIT] && ecc_uncorr;
            ev_set[vpm_pkg::ST_CORR]    = ecc_corr;
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status_q   <= '0;
            err_addr_q <= '0;
        end else begin
            status_q <= (status_q & ~((i_reg_wr && i_reg_addr == vpm_pkg::REG_STATUS)
                        ? i_reg_wdata[vpm_pkg::ST_W-1:0] : '0)) | ev_set;
            if (ev_set[vpm_pkg::ST_INVALID] || ev_set[vpm_pkg::ST_UNCORR]) begin
                err_addr_q <= cur_q.addr;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(status_q & mask_q);
        end
    end

    // Read data stand only in the cycle after the strobe; map reads never disturb the entry under test
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reg_rdata <= '0;
        end else begin
            o_reg_rdata <= '0;
            if (i_reg_rd) begin
                unique case (i_reg_addr)
                    vpm_pkg::REG_UTIL:   o_reg_rdata[vpm_pkg::MODE_MSB:vpm_pkg::MODE_LSB] <= mode_q;
                    vpm_pkg::REG_STATUS: o_reg_rdata[vpm_pkg::ST_W-1:0] <= status_q;
                    vpm_pkg::REG_MASK:   o_reg_rdata[vpm_pkg::ST_W-1:0] <= mask_q;
                    vpm_pkg::REG_ERRADR: o_reg_rdata <= err_addr_q;
                    vpm_pkg::REG_MAPIDX: o_reg_rdata[IDX_W-1:0] <= sw_idx_q;
                    vpm_pkg::REG_MAPDAT: o_reg_rdata <= map_data[sw_idx_q];
                    vpm_pkg::REG_MAPECC: o_reg_rdata[vpm_pkg::ECC_W-1:0] <= map_ecc[sw_idx_q];
                    default: ;
                endcase
            end
        end
    end
endmodule : vpm_translator
`default_nettype wire

// ==== tb/test_vme_dma_page_map_translator.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_vme_dma_page_map_translator;
    logic core_clk, reset_n, accept, abort, reg_wr, reg_rd, irq, go, go_write;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, go_addr, a, e, d, c;
    vpm_pkg::vpm_req_t req;
    vpm_pkg::vpm_sys_t sys;
    int n_mismatch = 0;
    int n_checks   = 0;
    int seed       = 53426;
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    vpm_vme_master u_vpm_vme_master (.i_core_clk(core_clk), .i_reset_n(reset_n), .i_go(go), .i_addr(go_addr),
        .i_write(go_write), .i_accept(accept), .o_req(req));
    vpm_translator u_vpm_translator (.i_core_clk(core_clk), .i_reset_n(reset_n), .i_req(req), .o_sys(sys),
        .o_accept(accept), .o_abort(abort), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_irq(irq));
    function automatic int top_bit(int m);
        return (m == 1 || m == 2) ? 25 : (m == 3) ? 28 : 29;
    endfunction : top_bit
    function automatic logic [15:0] idx_of(int m, logic [31:0] va);
        return (m == 3) ? va[27:12] : (m == 4) ? va[28:13] : va[24:9];
    endfunction : idx_of
    function automatic logic [39:0] exp_sys(int m, logic [31:0] va, logic [31:0] ve);
        case (m)
            0:       return {11'h000, va[28:0]};
            1:       return {6'h00, ve[24:0], va[8:0]};
            2:       return {1'b0, ve[29:0], va[8:0]};
            3:       return {1'b0, ve[26:0], va[11:0]};
            default: return {1'b0, ve[25:0], va[12:0]};
        endcase
    endfunction : exp_sys
    task automatic chk(input string nm, input logic [41:0] exp, input logic [41:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] ra, input logic [31:0] wd);
        @(posedge core_clk);
        reg_addr  <= ra;
        reg_wdata <= wd;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] ra, output logic [31:0] rd);
        @(posedge core_clk);
        reg_addr <= ra;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 rd = reg_rdata;
    endtask : rd_reg
    task automatic set_entry(input logic [15:0] idx, input logic [31:0] ve);
        wr_reg(vpm_pkg::REG_MAPIDX, {16'h0000, idx});
        wr_reg(vpm_pkg::REG_MAPDAT, ve);
    endtask : set_entry
    // Kind 0 expects a system cycle, 1 an abort, 2 no response at all
    task automatic xfer(input logic [31:0] va, input logic wr, input int kind, input logic [39:0] exp);
        logic hs, ha, hc, gw;
        logic [39:0] ga;
        {hs, ha, hc, gw, ga} = '0;
        @(posedge core_clk);
        go       <= 1'b1;
        go_addr  <= va;
        go_write <= wr;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (8) begin
            @(posedge core_clk);
            #1 hc = hc | accept;
            ha = ha | abort;
            if (sys.valid && !hs) begin
                {hs, gw, ga} = {1'b1, sys.write, sys.addr};
            end
        end
        if (kind == 0) chk("sys", {1'b1, wr, exp}, {hs, gw, ga});
        else if (kind == 1) chk("abort", 42'h2, {ha, hs});
        else chk("refuse", 42'h0, {hc, hs, ha});
    endtask : xfer
    task automatic print_verdict;
        if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    initial begin
        {reset_n, go, go_write, reg_wr, reg_rd, reg_addr, reg_wdata, go_addr} = '0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_reg(vpm_pkg::REG_UTIL, d);
        chk("util", 42'h0, d);
        wr_reg(vpm_pkg::REG_MASK, 32'h7);
        for (int m = 0; m < 5; m++) begin
            wr_reg(vpm_pkg::REG_UTIL, 32'(m) << 17);
            for (int k = 0; k < 6; k++) begin
                a = (k == 0) ? 32'hFFFF_FFFF : $random(seed);
                a = a & ((32'h1 << top_bit(m)) - 32'h1);
                e = $random(seed) | 32'h8000_0000;
                if (m != 0) set_entry(idx_of(m, a), e);
                xfer(a, k[0], 0, exp_sys(m, a, e));
            end
            xfer(a | (32'h1 << top_bit(m)), 1'b0, 2, 40'h0);
        end
        wr_reg(vpm_pkg::REG_UTIL, 32'h5 << 17);
        xfer(32'h0, 1'b0, 2, 40'h0);
        wr_reg(vpm_pkg::REG_UTIL, 32'h1 << 17);
        a = 32'h0000_1234;
        set_entry(idx_of(1, a), 32'h0000_0ABC);
        xfer(a, 1'b0, 1, 40'h0);
        rd_reg(vpm_pkg::REG_STATUS, d);
        chk("status", 42'h1, d);
        rd_reg(vpm_pkg::REG_ERRADR, d);
        chk("erradr", {10'h0, a}, d);
        chk("irq", 42'h1, irq);
        wr_reg(vpm_pkg::REG_STATUS, 32'h1);
        rd_reg(vpm_pkg::REG_STATUS, d);
        chk("cleared", 42'h0, {d, irq});
        wr_reg(vpm_pkg::REG_MASK, 32'h0);
        xfer(a, 1'b1, 1, 40'h0);
        chk("masked irq", 42'h0, irq);
        wr_reg(vpm_pkg::REG_STATUS, 32'h1);
        wr_reg(vpm_pkg::REG_MASK, 32'h7);
        e = 32'h8123_4567;
        set_entry(idx_of(1, a), e);
        rd_reg(vpm_pkg::REG_MAPECC, d);
        wr_reg(vpm_pkg::REG_MAPECC, {25'h0, d[6:0] ^ 7'h03});
        xfer(a, 1'b0, 1, 40'h0);
        rd_reg(vpm_pkg::REG_STATUS, c);
        chk("uncorr", 42'h2, c);
        wr_reg(vpm_pkg::REG_STATUS, 32'h2);
        wr_reg(vpm_pkg::REG_MAPECC, {25'h0, d[6:0] ^ 7'h01});
        xfer(a, 1'b1, 0, exp_sys(1, a, e));
        rd_reg(vpm_pkg::REG_STATUS, d);
        chk("corr", 42'h4, d);
        // A node reset in mid-run must fall back to pass-through
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_reg(vpm_pkg::REG_UTIL, d);
        chk("util after reset", 42'h0, d);
        xfer(32'h0000_0200, 1'b1, 0, {11'h000, 29'h0000_0200});
        print_verdict;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        print_verdict;
    end
endmodule : test_vme_dma_page_map_translator
`default_nettype wire

// ==== tb/vpm_translator_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module vpm_translator_chk #(
    parameter int IDX_W = vpm_pkg::IDX_W
) (
    input wire logic                      i_core_clk,
    input wire logic                      i_reset_n,
    input wire vpm_pkg::vpm_req_t         i_req,
    input wire vpm_pkg::vpm_sys_t         o_sys,
    input wire logic                      o_accept,
    input wire logic                      o_abort,
    input wire logic [vpm_pkg::RAW_W-1:0] i_reg_addr,
    input wire logic [vpm_pkg::DAT_W-1:0] i_reg_wdata,
    input wire logic                      i_reg_wr,
    input wire logic                      i_reg_rd,
    input wire logic [vpm_pkg::DAT_W-1:0] o_reg_rdata,
    input wire logic                      o_irq
);
    logic [2:0] mode_q;
    logic [2:0] mask_q;
    // Shadow copies of mode and mask, since the checker only sees the bus
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_q <= 3'h0;
            mask_q <= 3'h0;
        end else if (i_reg_wr && i_reg_addr == vpm_pkg::REG_UTIL) begin
            mode_q <= i_reg_wdata[19:17];
        end else if (i_reg_wr && i_reg_addr == vpm_pkg::REG_MASK) begin
            mask_q <= i_reg_wdata[2:0];
        end
    end
    function automatic logic in_rng(logic [2:0] m, logic [31:0] a);
        case (m)
            3'h0, 3'h4: return a[31:29] == 3'h0;
            3'h1, 3'h2: return a[31:25] == 7'h00;
            3'h3:       return a[31:28] == 4'h0;
            default:    return 1'b0;
        endcase
    endfunction : in_rng
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_quiet;
        !o_sys.valid && !o_abort;
    endsequence
    sequence s_answer;
        o_sys.valid != o_abort;
    endsequence
    range_refuse_a: assert property (i_req.valid && !in_rng(mode_q, i_req.addr) |=> !o_accept)
        else $error("out of range request accepted");
    pass_addr_a: assert property (o_accept && mode_q == 3'h0 |->
        o_sys.valid && o_sys.addr == {11'h000, $past(i_req.addr[28:0])}) else $error("pass address wrong");
    map_order_a: assert property (o_accept && mode_q != 3'h0 |-> s_quiet ##1 s_quiet ##1 s_answer)
        else $error("mapped answer out of step");
    addr34_a: assert property (o_sys.valid && mode_q == 3'h1 |->
        o_sys.addr[39:34] == 6'h00 && o_sys.addr[8:0] == $past(i_req.addr[8:0], 3)) else $error("34 bit addr");
    top40_a: assert property (o_sys.valid && mode_q inside {3'h2, 3'h3, 3'h4} |-> !o_sys.addr[39])
        else $error("io select set");
    off4k_a: assert property (o_sys.valid && mode_q == 3'h3 |-> o_sys.addr[11:0] == $past(i_req.addr[11:0], 3))
        else $error("4K offset wrong");
    off8k_a: assert property (o_sys.valid && mode_q == 3'h4 |-> o_sys.addr[12:0] == $past(i_req.addr[12:0], 3))
        else $error("8K offset wrong");
    abort_irq_a: assert property (o_abort && mask_q[1:0] == 2'h3 |-> ##[1:2] o_irq)
        else $error("abort not signalled");
    one_take_a: assert property (o_accept |=> !o_accept)
        else $error("request taken twice");
endmodule : vpm_translator_chk
bind vpm_translator vpm_translator_chk #(.IDX_W(IDX_W)) u_vpm_translator_chk (.i_core_clk, .i_reset_n, .i_req,
    .o_sys, .o_accept, .o_abort, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_irq);
`default_nettype wire

// ==== tb/vpm_vme_master.sv ====
`timescale 1ns/1ns
`default_nettype none
module vpm_vme_master (
    input  wire logic          i_core_clk,
    input  wire logic          i_reset_n,
    input  wire logic          i_go,
    input  wire logic [31:0]   i_addr,
    input  wire logic          i_write,
    input  wire logic          i_accept,
    output vpm_pkg::vpm_req_t  o_req
);
    logic [2:0] wait_q;
    // Holds the request until taken; gives up after six cycles if refused
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_req  <= '0;
            wait_q <= 3'h0;
        end else if (i_go) begin
            o_req  <= '{valid: 1'b1, write: i_write, addr: i_addr};
            wait_q <= 3'h0;
        end else if (o_req.valid && (i_accept || wait_q == 3'h5)) begin
            // Released lines show the inverse so stale values are never mistaken for live ones
            o_req.valid <= 1'b0;
            o_req.addr  <= ~o_req.addr;
            o_req.write <= ~o_req.write;
        end else if (o_req.valid) begin
            wait_q <= wait_q + 3'h1;
        end
    end
endmodule : vpm_vme_master
`default_nettype wire
